// file: rtcta_pkg.sv
// Constants, register map and state types for the RTC timekeeping block
package rtcta_pkg;
	// Clock rates
	localparam int unsigned     RTCTA_MCLK_HZ      = 100_000_000;
	localparam int unsigned     RTCTA_XTAL_HZ      = 32_768;
	localparam int unsigned     RTCTA_CAL500_HZ    = 500;
	localparam int unsigned     RTCTA_CAL500_HALF  = RTCTA_MCLK_HZ / (2 * RTCTA_CAL500_HZ);
	localparam logic [26:0]     RTCTA_PHASE_MOD    = 27'(RTCTA_MCLK_HZ);
	localparam logic [26:0]     RTCTA_PHASE_INC    = 27'(RTCTA_XTAL_HZ);
	// Trim scaling
	localparam logic [19:0]     RTCTA_PPM_MOD      = 20'hf4240;
	localparam logic [9:0]      RTCTA_PPM_LIMIT    = 10'h0f8;
	localparam logic [9:0]      RTCTA_PPM_PER_LSB  = 10'h002;
	localparam logic [8:0]      RTCTA_TRIM_MAX     = 9'(RTCTA_PPM_LIMIT / RTCTA_PPM_PER_LSB);
	// Counter end values
	localparam logic [7:0]      RTCTA_PRESCALE_END = 8'hff;
	localparam logic [6:0]      RTCTA_SUBSEC_END   = 7'h7f;
	localparam logic [7:0]      RTCTA_SEC_END      = 8'h3b;
	localparam logic [7:0]      RTCTA_MIN_END      = 8'h3b;
	localparam logic [7:0]      RTCTA_HOUR_END_24  = 8'h17;
	localparam logic [7:0]      RTCTA_HOUR_END_256 = 8'hff;
	// Register indices; byte address is four times the index
	localparam logic [7:0]      RTCTA_IDX_SETTINGS = 8'ha1;
	localparam logic [7:0]      RTCTA_IDX_SUBSEC   = 8'ha2;
	localparam logic [7:0]      RTCTA_IDX_SEC      = 8'ha3;
	localparam logic [7:0]      RTCTA_IDX_MIN      = 8'ha4;
	localparam logic [7:0]      RTCTA_IDX_HOUR     = 8'ha5;
	localparam logic [7:0]      RTCTA_IDX_LIMIT    = 8'ha6;
	localparam logic [7:0]      RTCTA_IDX_NOMINAL  = 8'hf6;
	localparam logic [7:0]      RTCTA_IDX_THERMAL  = 8'hf7;
	localparam logic [7:0]      RTCTA_IDX_PINCFG   = 8'hff;
	// Settings register fields
	localparam int unsigned     RTCTA_SET_MIDNIGHT = 7;
	localparam int unsigned     RTCTA_SET_DAYWRAP  = 6;
	localparam int unsigned     RTCTA_SET_BASE_LO  = 4;
	localparam int unsigned     RTCTA_SET_SINGLE   = 3;
	localparam int unsigned     RTCTA_SET_ALARM    = 2;
	localparam int unsigned     RTCTA_SET_ENABLE   = 1;
	localparam int unsigned     RTCTA_SET_RSVD     = 0;
	// Pin configuration fields
	localparam int unsigned     RTCTA_PIN_OUT_EN   = 7;
	localparam int unsigned     RTCTA_PIN_RATE_LO  = 5;

	// Interval tick base
	typedef enum logic [1:0] {
		RTCTA_BASE_SUBSEC,
		RTCTA_BASE_SEC,
		RTCTA_BASE_MIN,
		RTCTA_BASE_HOUR
	} rtcta_base_t;

	// Calibration pulse rate
	typedef enum logic [1:0] {
		RTCTA_RATE_1HZ,
		RTCTA_RATE_512HZ,
		RTCTA_RATE_500HZ,
		RTCTA_RATE_16KHZ
	} rtcta_rate_t;

	// Trim tick generator state
	typedef struct packed {
		logic [26:0] phase;
		logic [19:0] ppm_acc;
		logic        pend;
		logic        tick;
	} rtcta_trim_t;

	localparam rtcta_trim_t RTCTA_TRIM_RST = '{default: '0};

	// Timekeeping block state
	typedef struct packed {
		logic [7:0]  prescale;
		logic [6:0]  subsec;
		logic [7:0]  sec;
		logic [7:0]  min;
		logic [7:0]  hour;
		logic [7:0]  limit;
		logic [7:0]  nominal;
		logic [7:0]  thermal;
		logic        midnight;
		logic        day_wrap_select;
		rtcta_base_t tick_base;
		logic        single_shot_sel;
		logic        alarm;
		logic        ivl_enable;
		logic [7:0]  ivl_cnt;
		logic        ivl_done;
		logic        trim_pulse_out_en;
		rtcta_rate_t trim_pulse_rate;
		logic [16:0] div500;
		logic        sq500;
		logic        cal_pin;
		logic        event_p;
		logic [31:0] prdata;
	} rtcta_state_t;

	localparam rtcta_state_t RTCTA_STATE_RST = '{day_wrap_select: 1'b1, tick_base: RTCTA_BASE_SUBSEC,
		trim_pulse_rate: RTCTA_RATE_1HZ, default: '0};
endpackage

// file: rtcta_trim_tick.sv
// Calibrated 32.768 kHz tick enable with digital pulse insert and drop
`timescale 1ns/100ps
module rtcta_trim_tick
	import rtcta_pkg::*;
(
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	// Trim values, signed LSBs
	input  wire logic [7:0] i_nominal_trim,
	input  wire logic [7:0] i_thermal_trim,
	// Calibrated tick enable
	output logic            o_tick
);
	rtcta_trim_t        s_q;       // Registered state
	rtcta_trim_t        s_d;       // Next state
	logic signed [8:0]  sum;       // Raw trim sum
	logic signed [8:0]  clamped;   // Sum after limit
	logic [8:0]         mag;       // Magnitude in LSBs
	logic [19:0]        step;      // Magnitude in ppm
	logic [26:0]        phase_sum; // Phase plus increment
	logic [19:0]        ppm_sum;   // Error plus step
	logic               raw;       // Uncorrected tick

	// Trim sum, clamp and accumulators
	always_comb begin
		s_d = s_q;
		sum = $signed({i_nominal_trim[7], i_nominal_trim}) + $signed({i_thermal_trim[7], i_thermal_trim});
		clamped = sum;
		// Clamp to the correctable range
		if (sum > $signed(RTCTA_TRIM_MAX)) begin
			clamped = $signed(RTCTA_TRIM_MAX);
		end else if (sum < -$signed(RTCTA_TRIM_MAX)) begin
			clamped = -$signed(RTCTA_TRIM_MAX);
		end
		mag = clamped[8] ? 9'(-clamped) : 9'(clamped);
		step = 20'({1'b0, mag} * RTCTA_PPM_PER_LSB);
		// Fractional divider, mean rate exactly 32.768 kHz
		phase_sum = s_q.phase + RTCTA_PHASE_INC;
		raw = (phase_sum >= RTCTA_PHASE_MOD);
		s_d.phase = raw ? phase_sum - RTCTA_PHASE_MOD : phase_sum;
		ppm_sum = s_q.ppm_acc + step;
		// Extra tick placed one cycle after the real one
		s_d.tick = s_q.pend;
		s_d.pend = 1'b0;
		if (raw) begin
			if (ppm_sum >= RTCTA_PPM_MOD) begin
				// One million ppm of error collected: fix one pulse
				s_d.ppm_acc = ppm_sum - RTCTA_PPM_MOD;
				if (!clamped[8]) begin
					s_d.tick = 1'b1;
					s_d.pend = 1'b1;
				end
			end else begin
				s_d.ppm_acc = ppm_sum;
				s_d.tick = 1'b1;
			end
		end
	end

	// State register, power-on reset only
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			s_q <= RTCTA_TRIM_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_tick = s_q.tick;
endmodule

// file: rtcta_core.sv
// RTC timekeeping counters, interval alarm, trim and calibration output
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module rtcta_core
	import rtcta_pkg::*;
#(
	parameter int unsigned P_CAL500_HALF = RTCTA_CAL500_HALF
)(
	// Clock and resets
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire logic        i_warm_resetn,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	// Event towards interrupt controller
	output logic             o_clock_event,
	// Shared calibration pin
	output logic             o_cal_pin,
	output logic             o_cal_pin_en_n
);
	// Data path in short:
	// Fractional divider makes a mean 32.768 kHz enable
	// Trim inserts or drops single ticks of that enable
	// Eight-bit prescaler turns ticks into 1/128 s steps
	// Sub-second, seconds, minutes, hours carry in a chain
	// Interval counter follows one step of that chain
	// Calibration pin shows one of four square waves
	// All state but the trim divider's sits in one struct: one register process
	// holds the power-on reset, five combinational processes
	// work out everything else
	rtcta_state_t s_q;        // Registered state
	rtcta_state_t s_d;        // Next state
	logic         tick;       // Calibrated 32.768 kHz enable
	logic         subsec_tk;  // 1/128 s enable
	logic         sec_tk;     // One second enable
	logic         min_tk;     // One minute enable
	logic         hour_tk;    // One hour enable
	logic         day_wrap;   // Hours roll over
	logic         base_tk;    // Selected interval base
	logic [7:0]   ivl_next;   // Interval count plus one
	logic         alarm_evt;  // Interval alarm event
	logic         setup;      // APB setup cycle
	logic         wr;         // APB write access
	logic [7:0]   hour_end;   // Last hour value
	logic         cal_sel;    // Selected rate level

	// Low two address bits ignored; each register is one word
	// Upper index bits must be zero, so no aliases appear
	// True when the word address matches a register index
	function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
		hit = (addr[11:2] == {2'b00, idx});
	endfunction

	// True for any mapped register
	function automatic logic mapped(input logic [11:0] addr);
		mapped = hit(addr, RTCTA_IDX_SETTINGS) || hit(addr, RTCTA_IDX_SUBSEC)
			|| hit(addr, RTCTA_IDX_SEC) || hit(addr, RTCTA_IDX_MIN)
			|| hit(addr, RTCTA_IDX_HOUR) || hit(addr, RTCTA_IDX_LIMIT)
			|| hit(addr, RTCTA_IDX_NOMINAL) || hit(addr, RTCTA_IDX_THERMAL)
			|| hit(addr, RTCTA_IDX_PINCFG);
	endfunction

	// Reserved bit reads one, so writing back a read value
	// keeps it set; the write itself ignores that bit
	// Settings register as software sees it
	function automatic logic [7:0] settings_byte(input rtcta_state_t s);
		logic [7:0] b;
		b = 8'h00;
		b[RTCTA_SET_MIDNIGHT] = s.midnight;
		b[RTCTA_SET_DAYWRAP] = s.day_wrap_select;
		b[RTCTA_SET_BASE_LO +: 2] = s.tick_base;
		b[RTCTA_SET_SINGLE] = s.single_shot_sel;
		b[RTCTA_SET_ALARM] = s.alarm;
		b[RTCTA_SET_ENABLE] = s.ivl_enable;
		b[RTCTA_SET_RSVD] = 1'b1;
		settings_byte = b;
	endfunction

	// Unmapped addresses read zero; the error flag says why
	// Counters read on the fly, a carry may land between reads
	// Read data for one address, zero above bit 7
	function automatic logic [31:0] read_word(input logic [11:0] addr, input rtcta_state_t s);
		logic [7:0] b;
		b = 8'h00;
		if (hit(addr, RTCTA_IDX_SETTINGS)) begin
			b = settings_byte(s);
		end else if (hit(addr, RTCTA_IDX_SUBSEC)) begin
			b = {1'b0, s.subsec};
		end else if (hit(addr, RTCTA_IDX_SEC)) begin
			b = s.sec;
		end else if (hit(addr, RTCTA_IDX_MIN)) begin
			b = s.min;
		end else if (hit(addr, RTCTA_IDX_HOUR)) begin
			b = s.hour;
		end else if (hit(addr, RTCTA_IDX_LIMIT)) begin
			b = s.limit;
		end else if (hit(addr, RTCTA_IDX_NOMINAL)) begin
			b = s.nominal;
		end else if (hit(addr, RTCTA_IDX_THERMAL)) begin
			b = s.thermal;
		end else if (hit(addr, RTCTA_IDX_PINCFG)) begin
			b = {s.trim_pulse_out_en, s.trim_pulse_rate, 5'h00};
		end
		read_word = {24'h000000, b};
	endfunction

	// Trims come straight from the registers; a new value
	// acts on the next tick, no write sequence needed
	// Power-on reset clears the divider phase, so the first
	// tick comes one full tick period after reset
	// Trimmed time base feeding every counter but the 500 Hz divider
	rtcta_trim_tick u_trim (
		.i_mclk         (i_mclk),
		.i_resetn       (i_resetn),
		.i_nominal_trim (s_q.nominal),
		.i_thermal_trim (s_q.thermal),
		.o_tick         (tick)
	);

	// Each enable is one cycle wide and nests in the one below
	// End values compare with >= so an out-of-range value
	// written by software wraps at its next carry instead of
	// running on through 255
	// Hours wrap is the day event; nothing sits above it
	// Counter cascade enables
	always_comb begin
		subsec_tk = tick && (s_q.prescale == RTCTA_PRESCALE_END);
		sec_tk = subsec_tk && (s_q.subsec == RTCTA_SUBSEC_END);
		min_tk = sec_tk && (s_q.sec >= RTCTA_SEC_END);
		hour_tk = min_tk && (s_q.min >= RTCTA_MIN_END);
		// Select set means 24 hours, cleared means 256 hours
		// Day length picked by the wrap select
		hour_end = s_q.day_wrap_select ? RTCTA_HOUR_END_24 : RTCTA_HOUR_END_256;
		day_wrap = hour_tk && (s_q.hour >= hour_end);
	end

	// Changing the base while enabled mixes two time bases
	// in the count already gathered; disable first
	// Interval base selection
	always_comb begin
		case (s_q.tick_base)
			RTCTA_BASE_SUBSEC: base_tk = subsec_tk;
			RTCTA_BASE_SEC:    base_tk = sec_tk;
			RTCTA_BASE_MIN:    base_tk = min_tk;
			RTCTA_BASE_HOUR:   base_tk = hour_tk;
			default:           base_tk = 1'b0;
		endcase
	end

	// 1 Hz, 512 Hz and 16 kHz come from the trimmed chain
	// 500 Hz comes from the system clock and carries no trim,
	// a short-window reference for the clock itself
	// Calibration rate selection
	always_comb begin
		case (s_q.trim_pulse_rate)
			RTCTA_RATE_1HZ:   cal_sel = s_q.subsec[6];
			RTCTA_RATE_512HZ: cal_sel = s_q.prescale[5];
			RTCTA_RATE_500HZ: cal_sel = s_q.sq500;
			RTCTA_RATE_16KHZ: cal_sel = s_q.prescale[0];
			default:          cal_sel = 1'b0;
		endcase
	end

	// No wait states: every access phase ends in one cycle
	// Read data is taken in setup, so a counter read shows
	// the value one cycle before the access edge
	// APB phase decode
	always_comb begin
		setup = i_psel && !i_penable;
		wr = i_psel && i_penable && i_pwrite;
		// Eight-bit counter wraps naturally
		ivl_next = s_q.ivl_cnt + 8'h01;
		alarm_evt = s_q.ivl_enable && !s_q.ivl_done && base_tk && (ivl_next == s_q.limit);
	end

	// Section order sets the priorities:
	// software writes beat a same-cycle counter carry,
	// hardware flag sets beat a same-cycle software clear,
	// warm reset beats all but time, prescaler, trims, 500 Hz divider and read data,
	// pin level is worked out last from the final enable
	// Next-state logic: counters, then software writes, then warm reset
	always_comb begin
		s_d = s_q;
		s_d.event_p = 1'b0;

		// Counters move only on their own enable; between
		// enables they are plain registers software may set
		// Prescaler and time counters on the trimmed tick
		if (tick) begin
			s_d.prescale = s_q.prescale + 8'h01;
		end
		if (subsec_tk) begin
			s_d.subsec = (s_q.subsec == RTCTA_SUBSEC_END) ? 7'h00 : s_q.subsec + 7'h01;
		end
		if (sec_tk) begin
			s_d.sec = (s_q.sec >= RTCTA_SEC_END) ? 8'h00 : s_q.sec + 8'h01;
		end
		if (min_tk) begin
			s_d.min = (s_q.min >= RTCTA_MIN_END) ? 8'h00 : s_q.min + 8'h01;
		end
		if (hour_tk) begin
			s_d.hour = day_wrap ? 8'h00 : s_q.hour + 8'h01;
		end

		// Limit zero is met only after a wrap, i.e. 256 ticks
		// Single shot keeps the count at zero until disabled
		// Interval counter
		if (!s_q.ivl_enable) begin
			// Disabled timer holds count and done in reset
			s_d.ivl_cnt = 8'h00;
			s_d.ivl_done = 1'b0;
		end else if (alarm_evt) begin
			// Either restart or stop until re-enabled
			s_d.ivl_cnt = 8'h00;
			s_d.ivl_done = s_q.single_shot_sel;
		end else if (base_tk && !s_q.ivl_done) begin
			s_d.ivl_cnt = ivl_next;
		end

		// Half period is a parameter so benches can shorten it
		// Runs free; warm reset leaves it alone
		// 500 Hz square wave from the system clock
		if (s_q.div500 >= 17'(P_CAL500_HALF - 1)) begin
			s_d.div500 = 17'h00000;
			s_d.sq500 = !s_q.sq500;
		end else begin
			s_d.div500 = s_q.div500 + 17'h00001;
		end

		// Held until the next setup, stable through the access
		// Read data captured in the setup cycle
		if (setup) begin
			s_d.prdata = read_word(i_paddr, s_q);
		end

		// Unmapped writes match nothing below and change nothing
		// Only the low byte of the write data is used
		// Register writes take effect at the access edge
		if (wr) begin
			if (hit(i_paddr, RTCTA_IDX_SETTINGS)) begin
				s_d.day_wrap_select = i_pwdata[RTCTA_SET_DAYWRAP];
				s_d.tick_base = rtcta_base_t'(i_pwdata[RTCTA_SET_BASE_LO +: 2]);
				s_d.single_shot_sel = i_pwdata[RTCTA_SET_SINGLE];
				s_d.ivl_enable = i_pwdata[RTCTA_SET_ENABLE];
				// Flags clear on zero; writing one does nothing
				if (!i_pwdata[RTCTA_SET_MIDNIGHT]) begin
					s_d.midnight = 1'b0;
				end
				if (!i_pwdata[RTCTA_SET_ALARM]) begin
					s_d.alarm = 1'b0;
				end
			end
			if (hit(i_paddr, RTCTA_IDX_SUBSEC)) begin
				s_d.subsec = i_pwdata[6:0];
			end
			if (hit(i_paddr, RTCTA_IDX_SEC)) begin
				s_d.sec = i_pwdata[7:0];
			end
			if (hit(i_paddr, RTCTA_IDX_MIN)) begin
				s_d.min = i_pwdata[7:0];
			end
			if (hit(i_paddr, RTCTA_IDX_HOUR)) begin
				s_d.hour = i_pwdata[7:0];
			end
			if (hit(i_paddr, RTCTA_IDX_LIMIT)) begin
				s_d.limit = i_pwdata[7:0];
			end
			if (hit(i_paddr, RTCTA_IDX_NOMINAL)) begin
				s_d.nominal = i_pwdata[7:0];
			end
			if (hit(i_paddr, RTCTA_IDX_THERMAL)) begin
				s_d.thermal = i_pwdata[7:0];
			end
			if (hit(i_paddr, RTCTA_IDX_PINCFG)) begin
				s_d.trim_pulse_out_en = i_pwdata[RTCTA_PIN_OUT_EN];
				s_d.trim_pulse_rate = rtcta_rate_t'(i_pwdata[RTCTA_PIN_RATE_LO +: 2]);
			end
		end

		// Day wrap and alarm in one cycle give one pulse;
		// the two flags tell them apart
		// Hardware set beats a same-cycle software clear
		if (day_wrap) begin
			s_d.midnight = 1'b1;
		end
		if (alarm_evt) begin
			s_d.alarm = 1'b1;
		end
		s_d.event_p = day_wrap || alarm_evt;

		// Keeping prescaler and sub-second count avoids losing
		// up to a second on every watchdog or external reset
		// Warm reset spares time, prescaler and trims
		if (!i_warm_resetn) begin
			s_d.limit = RTCTA_STATE_RST.limit;
			s_d.midnight = RTCTA_STATE_RST.midnight;
			s_d.day_wrap_select = RTCTA_STATE_RST.day_wrap_select;
			s_d.tick_base = RTCTA_STATE_RST.tick_base;
			s_d.single_shot_sel = RTCTA_STATE_RST.single_shot_sel;
			s_d.alarm = RTCTA_STATE_RST.alarm;
			s_d.ivl_enable = RTCTA_STATE_RST.ivl_enable;
			s_d.ivl_cnt = RTCTA_STATE_RST.ivl_cnt;
			s_d.ivl_done = RTCTA_STATE_RST.ivl_done;
			s_d.trim_pulse_out_en = RTCTA_STATE_RST.trim_pulse_out_en;
			s_d.trim_pulse_rate = RTCTA_STATE_RST.trim_pulse_rate;
			s_d.event_p = 1'b0;
		end

		// Source follows the registered rate, so a rate change
		// shows one cycle of the old source first
		// Pin level follows the selected rate while enabled
		s_d.cal_pin = s_d.trim_pulse_out_en && cal_sel;
	end

	// Inputs are synchronous to the system clock, so no
	// synchronisers sit in front of the reset or the bus
	// State register; only the power-on reset clears everything
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			s_q <= RTCTA_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Ready and error follow the bus phase directly;
	// the next setup may follow the access at once
	// Zero-wait APB answer; unmapped addresses flag an error
	assign o_pready = i_psel && i_penable;
	assign o_pslverr = i_psel && i_penable && !mapped(i_paddr);
	assign o_prdata = s_q.prdata;

	// Event, pin level and pin enable all come from flops,
	// so no combinational glitch reaches the shared pin
	// Outputs from flops
	assign o_clock_event = s_q.event_p;
	assign o_cal_pin = s_q.cal_pin;
	assign o_cal_pin_en_n = !s_q.trim_pulse_out_en;
endmodule

// file: rtcta_core_asserts.sv
// Port-level assertions for the RTC timekeeping block
`timescale 1ns/100ps
module rtcta_core_asserts
	import rtcta_pkg::*;
#(
	parameter int unsigned P_CAL500_HALF = RTCTA_CAL500_HALF
)(
	// Clock and resets
	input wire logic        i_mclk,
	input wire logic        i_resetn,
	input wire logic        i_warm_resetn,
	// APB
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pslverr,
	// Event and pin
	input wire logic        o_clock_event,
	input wire logic        o_cal_pin,
	input wire logic        o_cal_pin_en_n
);
	logic [7:0]  pin_q;  // Shadow pin config
	logic [7:0]  nom_q;  // Shadow nominal trim
	logic [7:0]  thr_q;  // Shadow thermal trim
	logic [7:0]  lim_q;  // Shadow alarm limit
	logic [12:0] gap_q;  // Cycles since last pin edge
	logic [1:0]  seen_q; // Pin edges seen under current config
	logic        cal_q;  // Pin one cycle ago
	wire         wr_acc = i_psel && i_penable && i_pwrite;
	wire         tog    = o_cal_pin != cal_q;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn || !i_warm_resetn);

	// Shadows of software writes; trims survive warm reset
	always_ff @(posedge i_mclk) begin
		cal_q <= o_cal_pin;
		if (!i_resetn) begin
			nom_q <= 8'h00;
			thr_q <= 8'h00;
		end else if (wr_acc && i_paddr == 12'h3d8) begin
			nom_q <= i_pwdata[7:0];
		end else if (wr_acc && i_paddr == 12'h3dc) begin
			thr_q <= i_pwdata[7:0];
		end
		if (!i_resetn || !i_warm_resetn) begin
			pin_q <= 8'h00;
			lim_q <= 8'h00;
		end else if (wr_acc && i_paddr == 12'h3fc) begin
			pin_q <= i_pwdata[7:0];
		end else if (wr_acc && i_paddr == 12'h298) begin
			lim_q <= i_pwdata[7:0];
		end
	end

	// Gap counter; a config write forgets the old phase
	always_ff @(posedge i_mclk) begin
		if (!i_resetn || !i_warm_resetn || (wr_acc && i_paddr == 12'h3fc)) begin
			gap_q  <= 13'h0000;
			seen_q <= 2'b00;
		end else if (tog) begin
			gap_q  <= 13'h0000;
			// First edge may come from the switch itself
			if (seen_q != 2'b11) begin
				seen_q <= seen_q + 2'b01;
			end
		end else if (gap_q != 13'h1fff) begin
			gap_q <= gap_q + 13'h0001;
		end
	end

	// Read access to one register
	sequence s_rd(logic [11:0] a);
		i_psel && i_penable && !i_pwrite && i_paddr == a;
	endsequence

	AST_PIN_DRIVE: assert property (o_cal_pin_en_n == !pin_q[7])
		else $error("pin enable does not follow config bit 7");
	AST_PIN_QUIET: assert property (o_cal_pin_en_n |-> !o_cal_pin)
		else $error("cal pin active while not driven");
	AST_RATE_500: assert property (tog && seen_q[1] && pin_q[7:5] == 3'b110 |-> gap_q == P_CAL500_HALF - 1)
		else $error("500 Hz half period wrong");
	AST_RATE_16K: assert property (pin_q[7:5] == 3'b111 |-> gap_q <= 13'd6200)
		else $error("16 kHz output stalled");
	AST_EVENT_PULSE: assert property (o_clock_event |=> !o_clock_event [*8])
		else $error("clock event longer than one cycle");
	AST_NOM_READ: assert property (s_rd(12'h3d8) |-> o_prdata == {24'h000000, nom_q})
		else $error("nominal trim readback wrong");
	AST_THR_KEEP: assert property (s_rd(12'h3dc) |-> o_prdata == {24'h000000, thr_q})
		else $error("thermal trim readback wrong");
	AST_LIMIT_READ: assert property (s_rd(12'h298) |-> o_prdata == {24'h000000, lim_q})
		else $error("alarm limit readback wrong");
endmodule

bind rtcta_core rtcta_core_asserts #(.P_CAL500_HALF(P_CAL500_HALF)) i_asserts (
	.i_mclk(i_mclk), .i_resetn(i_resetn), .i_warm_resetn(i_warm_resetn), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_clock_event(o_clock_event),
	.o_cal_pin(o_cal_pin), .o_cal_pin_en_n(o_cal_pin_en_n));

// file: testbench.sv
// Self-checking bench for the RTC timekeeping block
`timescale 1ns/100ps
module testbench;
	import rtcta_pkg::*;
	localparam int unsigned HALF = 10; // Short 500 Hz half period
	logic        i_mclk, i_resetn, i_warm_resetn, i_psel, i_penable, i_pwrite;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic        o_pready, o_pslverr, o_clock_event, o_cal_pin, o_cal_pin_en_n, serr;
	int          err_total, checked;

	rtcta_core #(.P_CAL500_HALF(HALF)) i_dut (
		.i_mclk(i_mclk), .i_resetn(i_resetn), .i_warm_resetn(i_warm_resetn), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_clock_event(o_clock_event),
		.o_cal_pin(o_cal_pin), .o_cal_pin_en_n(o_cal_pin_en_n));

	// Verdict and end of run
	task automatic summarize();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// One compare, counted
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; idle edge first so no signal is set twice at once
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		@(posedge i_mclk);
		i_psel   <= 1'b1;
		i_pwrite <= wr;
		i_paddr  <= {2'b00, idx, 2'b00};
		i_pwdata <= {24'h000000, wd};
		@(posedge i_mclk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			summarize();
		end
		rd = o_prdata;
		serr = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	// Read one register and compare the whole word, upper bytes zero
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h000000, exp});
	endtask

	// Reset pulse, power-on or warm
	task automatic pulse(input logic por);
		@(posedge i_mclk);
		if (por) i_resetn <= 1'b0;
		else i_warm_resetn <= 1'b0;
		repeat (10) @(posedge i_mclk);
		i_resetn <= 1'b1;
		i_warm_resetn <= 1'b1;
	endtask

	// Cycles until the cal pin changes, bounded
	task automatic wait_tog(input int lim, output int n);
		logic p;
		p = o_cal_pin;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_cal_pin === p && n < lim);
		if (n >= lim) begin
			err_total++;
			summarize();
		end
	endtask

	// Defaults after power-on and an unmapped access
	task automatic t_defaults();
		rd_chk(RTCTA_IDX_SETTINGS, 8'h41);
		rd_chk(RTCTA_IDX_SEC, 8'h00);
		rd_chk(RTCTA_IDX_HOUR, 8'h00);
		rd_chk(RTCTA_IDX_THERMAL, 8'h00);
		chk({31'h0, o_cal_pin_en_n}, 32'h1);
		apb(1'b1, 8'h00, 8'h55);
		chk({31'h0, serr}, 32'h1);
		rd_chk(8'h00, 8'h00);
	endtask

	// Write and read back time, limit and trim registers, then the settings bits
	task automatic t_regs();
		logic [7:0] idx [6];
		logic [7:0] val [6];
		idx = '{RTCTA_IDX_SEC, RTCTA_IDX_MIN, RTCTA_IDX_HOUR, RTCTA_IDX_LIMIT, RTCTA_IDX_NOMINAL, RTCTA_IDX_THERMAL};
		val = '{8'h3b, 8'h3b, 8'hff, 8'hff, 8'h7f, 8'h80};
		foreach (idx[k]) begin
			apb(1'b1, idx[k], val[k]);
			rd_chk(idx[k], val[k]);
		end
		apb(1'b1, RTCTA_IDX_SETTINGS, 8'hfe);
		rd_chk(RTCTA_IDX_SETTINGS, 8'h7b);
	endtask

	// Warm reset keeps time and trims, power-on clears them
	task automatic t_resets();
		pulse(1'b0);
		rd_chk(RTCTA_IDX_SEC, 8'h3b);
		rd_chk(RTCTA_IDX_MIN, 8'h3b);
		rd_chk(RTCTA_IDX_HOUR, 8'hff);
		rd_chk(RTCTA_IDX_NOMINAL, 8'h7f);
		rd_chk(RTCTA_IDX_THERMAL, 8'h80);
		rd_chk(RTCTA_IDX_LIMIT, 8'h00);
		chk({31'h0, o_clock_event}, 32'h0);
		rd_chk(RTCTA_IDX_SETTINGS, 8'h41);
		pulse(1'b1);
		rd_chk(RTCTA_IDX_MIN, 8'h00);
		rd_chk(RTCTA_IDX_NOMINAL, 8'h00);
	endtask

	// Calibration output at 500 Hz and 16 kHz, then off
	task automatic t_cal();
		int n;
		apb(1'b1, RTCTA_IDX_PINCFG, 8'hc0);
		repeat (3) @(posedge i_mclk);
		chk({31'h0, o_cal_pin_en_n}, 32'h0);
		wait_tog(40, n);
		wait_tog(40, n);
		chk(n, HALF);
		apb(1'b1, RTCTA_IDX_PINCFG, 8'he0);
		// First edge may be the rate switch, second a partial period
		wait_tog(6200, n);
		wait_tog(6200, n);
		wait_tog(6200, n);
		chk({31'h0, n inside {[3051:3053]}}, 32'h1);
		apb(1'b1, RTCTA_IDX_PINCFG, 8'h00);
		repeat (3) @(posedge i_mclk);
		chk({30'h0, o_cal_pin_en_n, o_cal_pin}, 32'h2);
	endtask

	// Free-running clock
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	// Main sequence
	initial begin
		err_total = 0;
		checked = 0;
		i_resetn = 1'b0;
		i_warm_resetn = 1'b1;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 12'h000;
		i_pwdata = 32'h00000000;
		repeat (10) @(posedge i_mclk);
		i_resetn <= 1'b1;
		t_defaults();
		t_regs();
		t_resets();
		t_cal();
		summarize();
	end
endmodule
